// ===== rtl/uev_pkg.sv
package uev_pkg;
  localparam int ADDR_W = 8;
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_SC_EN = 6'h05;
  localparam logic [5:0] IDX_SC_FLAGS = 6'h06;
  localparam logic [5:0] IDX_ST_EN = 6'h07;
  localparam logic [5:0] IDX_ST_FLAGS = 6'h08;
  localparam logic [5:0] IDX_MODE = 6'h09;
  localparam logic [5:0] IDX_DIR_DELAY = 6'h10;
  localparam logic [5:0] IDX_CFG = 6'h11;
  localparam logic [5:0] IDX_BRK_LEN = 6'h12;
  localparam int SC_ADDR = 5;
  localparam int SC_BREAK = 4;
  localparam int ST_TXE = 7;
  localparam int ST_SLEEP = 6;
  localparam int ST_CLK = 5;
  localparam int MD_AUTO_SLEEP = 6;
  localparam int MD_SLEEP_FORCE = 5;
  localparam int MD_AUTO_DIR = 4;
  localparam int MD_RTS_TRI = 3;
  localparam int MD_TX_TRI = 2;
  localparam int MD_TX_HALT = 1;
  localparam int MD_RX_HALT = 0;
  localparam int CFG_MULTIDROP = 0;
  localparam int CFG_SPECIAL = 1;
  localparam int CFG_CRYSTAL = 2;
  localparam int CFG_CLK_EN = 3;
  localparam logic [7:0] SC_EN_MASK = 8'h3f;
  localparam logic [7:0] ST_EN_MASK = 8'hef;
  localparam logic [7:0] MODE_MASK = 8'h7f;
  localparam logic [7:0] CFG_MASK = 8'h0f;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h08;
  localparam logic [15:0] BRK_LEN_RESET = 16'h01f4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_MHZ = 50;
  localparam int AUTO_SLEEP_US = 1000;
  localparam int AUTO_SLEEP_CYCLES = AUTO_SLEEP_US * CLK_MHZ;
  localparam int DELAY_UNIT_NS = 320;
  localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_NS * CLK_MHZ / 1000;
  typedef enum logic [3:0] {
    UEV_D_IDLE = 4'h1,
    UEV_D_SETUP = 4'h2,
    UEV_D_SEND = 4'h4,
    UEV_D_HOLD = 4'h8
  } uev_dir_e;
endpackage

// ===== rtl/uev_timer_if.sv
`timescale 1ns/1ns
interface uev_timer_if;
  logic start;
  logic [3:0] count;
  logic done;
  modport owner (output start, output count, input done);
  modport timer (input start, input count, output done);
endinterface

// ===== rtl/uev_delay_timer.sv
`timescale 1ns/1ns
module uev_delay_timer #(
  parameter int UNIT = uev_pkg::DELAY_UNIT_CYCLES
) (
  input wire logic aclk, // Clock.
  input wire logic rst, // Synchronous reset, active high.
  uev_timer_if.timer t // Start, length in units, done pulse.
);
  localparam int UW = $clog2(UNIT + 1);
  logic busy;
  logic [3:0] units;
  logic [UW-1:0] tick;
  wire unit_end = (tick == UW'(UNIT - 1));

  // Done pulses count*UNIT+1 cycles after the start edge, or one cycle for zero.
  always_ff @(posedge aclk) begin
    if (rst) begin
      busy <= 1'b0;
      units <= 4'h0;
      tick <= '0;
      t.done <= 1'b0;
    end else begin
      t.done <= 1'b0;
      if (t.start) begin
        busy <= (t.count != 4'h0);
        units <= t.count;
        tick <= '0;
        t.done <= (t.count == 4'h0);
      end else if (busy) begin
        tick <= unit_end ? '0 : tick + 1'b1;
        if (unit_end) begin
          units <= units - 4'h1;
          if (units == 4'h1) begin
            busy <= 1'b0;
            t.done <= 1'b1;
          end
        end
      end
    end
  end

  a_zero_delay: assert property (@(posedge aclk) disable iff (rst)
    t.start && t.count == 4'h0 |=> t.done)
    else $error("zero delay did not finish in one cycle");
endmodule

// ===== rtl/uev_top.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
module uev_top #(
  parameter int CHANNEL = 0,
  parameter int AUTO_SLEEP_CYCLES = uev_pkg::AUTO_SLEEP_CYCLES,
  parameter int DELAY_UNIT = uev_pkg::DELAY_UNIT_CYCLES
) (
  input wire logic aclk, // Clock, 50 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic soft_reset, // Per-channel software reset.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic [2:0] s_axi_awprot, // Unused.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic [2:0] s_axi_arprot, // Unused.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic rx_char_valid, // Pulse: a character was received.
  input wire logic rx_char_is_address, // Ninth bit marks an address.
  input wire logic [3:0] rx_char_match, // Resume1, resume2, pause1, pause2.
  input wire logic rx_line, // Receive line level.
  input wire logic [7:0] gpio_in, // All eight pin levels.
  input wire logic tx_fifo_empty, // Transmit FIFO empty.
  input wire logic tx_shift_idle, // Transmit shifter idle.
  input wire logic tx_serial, // Serial data from the shifter.
  input wire logic rts_level, // Request-to-send level when not automatic.
  input wire logic clock_settled, // Oscillator, predivider and PLL settled.
  input wire logic line_activity, // Any link or host activity.
  output logic tx_pin, // Transmit pin output.
  output logic tx_oe, // Transmit pin enable.
  output logic rts_pin, // Request-to-send pin output.
  output logic rts_oe, // Request-to-send pin enable.
  output logic tx_permit, // Transmitter may start a character.
  output logic tx_halt, // Transmitter disabled.
  output logic rx_enable, // Receiver accepts characters.
  output logic sleeping, // Channel in low-power sleep.
  output logic isr_special, // Summary bit 1.
  output logic isr_status, // Summary bit 2.
  output logic isr_tx_empty // Summary bit 5.
);
  localparam int IW = $clog2(AUTO_SLEEP_CYCLES + 1);
  wire rst = !aresetn || soft_reset;

  logic aw_held, w_held;
  logic [5:0] aw_idx;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [7:0] sc_en, st_en, mode, dir_delay, cfg;
  logic [15:0] brk_len, brk_cnt;
  logic brk_seen;
  logic [5:0] sc;
  logic [7:0] st;
  logic [3:0] gp_prev;
  logic gp_ready, txe_prev;
  logic [IW-1:0] idle_cnt;
  uev_pkg::uev_dir_e dstate, next_dstate;
  uev_timer_if setup_t ();
  uev_timer_if hold_t ();

  // Bus decode.
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire wr_b0 = wr_go && wstrb_q[0];
  wire wr_b1 = wr_go && wstrb_q[1];
  wire [5:0] ar_idx = s_axi_araddr[7:2];
  wire wr_sc_en = wr_b0 && aw_idx == uev_pkg::IDX_SC_EN;
  wire wr_st_en = wr_b0 && aw_idx == uev_pkg::IDX_ST_EN;
  wire wr_mode = wr_b0 && aw_idx == uev_pkg::IDX_MODE;
  wire wr_delay = wr_b0 && aw_idx == uev_pkg::IDX_DIR_DELAY;
  wire wr_cfg = wr_b0 && aw_idx == uev_pkg::IDX_CFG;
  wire wr_brk = aw_idx == uev_pkg::IDX_BRK_LEN;
  wire wr_known = wr_brk || aw_idx inside {[uev_pkg::IDX_SC_EN : uev_pkg::IDX_MODE],
    uev_pkg::IDX_DIR_DELAY, uev_pkg::IDX_CFG};
  wire rd_sc = ar_fire && ar_idx == uev_pkg::IDX_SC_FLAGS;
  wire rd_st = ar_fire && ar_idx == uev_pkg::IDX_ST_FLAGS;
  wire [7:0] mode_rd = {mode[7:6], sleeping, mode[4:0]};
  wire rd_known = ar_idx inside {[uev_pkg::IDX_SC_EN : uev_pkg::IDX_MODE],
    uev_pkg::IDX_DIR_DELAY, uev_pkg::IDX_CFG, uev_pkg::IDX_BRK_LEN};
  wire [15:0] rd_val =
    (ar_idx == uev_pkg::IDX_SC_EN) ? {8'h00, sc_en} :
    (ar_idx == uev_pkg::IDX_SC_FLAGS) ? {10'h000, sc} :
    (ar_idx == uev_pkg::IDX_ST_EN) ? {8'h00, st_en} :
    (ar_idx == uev_pkg::IDX_ST_FLAGS) ? {8'h00, st} :
    (ar_idx == uev_pkg::IDX_MODE) ? {8'h00, mode_rd} :
    (ar_idx == uev_pkg::IDX_DIR_DELAY) ? {8'h00, dir_delay} :
    (ar_idx == uev_pkg::IDX_CFG) ? {8'h00, cfg} :
    (ar_idx == uev_pkg::IDX_BRK_LEN) ? brk_len : 16'h0000;

  // Receive-side events.
  wire rx_ok = rx_char_valid && !mode[uev_pkg::MD_RX_HALT];
  wire spec_ok = rx_ok && cfg[uev_pkg::CFG_SPECIAL];
  wire brk_hit = !rx_line && !brk_seen && brk_cnt == brk_len;
  wire [5:0] sc_set = {rx_ok && cfg[uev_pkg::CFG_MULTIDROP] && rx_char_is_address,
    brk_hit, spec_ok ? rx_char_match : 4'h0};
  wire sc_pend = |(sc & sc_en[5:0]);

  // Status-side events.
  wire [3:0] gp_now = gpio_in[CHANNEL*4 +: 4];
  wire [3:0] gp_chg = gp_ready ? (gp_now ^ gp_prev) & st_en[3:0] : 4'h0;
  wire txe_now = tx_fifo_empty && tx_shift_idle;
  wire txe_set = txe_now && !txe_prev;
  wire clk_en = cfg[uev_pkg::CFG_CLK_EN];
  wire st_pend = |(st & st_en);

  // Sleep control.
  wire auto_sleep = mode[uev_pkg::MD_AUTO_SLEEP];
  wire idle_done = idle_cnt == IW'(AUTO_SLEEP_CYCLES - 1);
  wire next_sleeping = mode[uev_pkg::MD_SLEEP_FORCE] ||
    (auto_sleep && !line_activity && (sleeping || idle_done));
  wire sleep_enter = next_sleeping && !sleeping;
  wire sleep_leave = sleeping && !next_sleeping;

  // Direction control.
  wire auto_dir = mode[uev_pkg::MD_AUTO_DIR];
  assign setup_t.start = dstate == uev_pkg::UEV_D_IDLE && auto_dir && !tx_fifo_empty;
  assign setup_t.count = dir_delay[7:4];
  assign hold_t.start = dstate == uev_pkg::UEV_D_SEND && txe_now;
  assign hold_t.count = dir_delay[3:0];

  always_comb begin
    next_dstate = dstate;
    unique case (dstate)
      uev_pkg::UEV_D_IDLE: if (setup_t.start) next_dstate = uev_pkg::UEV_D_SETUP;
      uev_pkg::UEV_D_SETUP: if (setup_t.done) next_dstate = uev_pkg::UEV_D_SEND;
      uev_pkg::UEV_D_SEND: if (hold_t.start) next_dstate = uev_pkg::UEV_D_HOLD;
      uev_pkg::UEV_D_HOLD: if (hold_t.done) next_dstate = uev_pkg::UEV_D_IDLE;
      default: next_dstate = uev_pkg::UEV_D_IDLE;
    endcase
    if (!auto_dir) begin
      next_dstate = uev_pkg::UEV_D_IDLE;
    end
  end

  uev_delay_timer #(.UNIT(DELAY_UNIT)) u_setup (.aclk(aclk), .rst(rst), .t(setup_t));
  uev_delay_timer #(.UNIT(DELAY_UNIT)) u_hold (.aclk(aclk), .rst(rst), .t(hold_t));

  // Write channel: address and data taken in either order.
  always_ff @(posedge aclk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 6'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= uev_pkg::RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[7:2];
        s_axi_awready <= 1'b0;
      end
      if (w_fire) begin
        w_held <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? uev_pkg::RESP_OKAY : uev_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel; a flag register read clears its event flags, but not the sleep or clock bits, at the address edge.
  always_ff @(posedge aclk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= uev_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_val};
      s_axi_rresp <= rd_known ? uev_pkg::RESP_OKAY : uev_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Software registers; bits without a function are masked off.
  always_ff @(posedge aclk) begin
    if (rst) begin
      sc_en <= uev_pkg::REG_RESET;
      st_en <= uev_pkg::REG_RESET;
      mode <= uev_pkg::REG_RESET;
      dir_delay <= uev_pkg::REG_RESET;
      cfg <= uev_pkg::CFG_RESET;
      brk_len <= uev_pkg::BRK_LEN_RESET;
    end else begin
      if (wr_sc_en) sc_en <= wdata_q[7:0] & uev_pkg::SC_EN_MASK;
      if (wr_st_en) st_en <= wdata_q[7:0] & uev_pkg::ST_EN_MASK;
      if (wr_mode) mode <= wdata_q[7:0] & uev_pkg::MODE_MASK;
      if (wr_delay) dir_delay <= wdata_q[7:0];
      if (wr_cfg) cfg <= wdata_q[7:0] & uev_pkg::CFG_MASK;
      if (wr_brk && wr_b0) brk_len[7:0] <= wdata_q[7:0];
      if (wr_brk && wr_b1) brk_len[15:8] <= wdata_q[15:8];
    end
  end

  // Event flags; a set in a read-clearing cycle wins over the clear, but clock enable low clears the sleep and clock bits.
  always_ff @(posedge aclk) begin
    if (rst) begin
      sc <= 6'h00;
      st <= uev_pkg::REG_RESET;
      brk_cnt <= 16'h0000;
      brk_seen <= 1'b0;
      gp_prev <= 4'h0;
      gp_ready <= 1'b0;
      txe_prev <= 1'b1;
    end else begin
      sc <= (rd_sc ? 6'h00 : sc) | sc_set;
      brk_seen <= !rx_line && (brk_seen || brk_hit);
      brk_cnt <= (rx_line || brk_seen || brk_hit) ? 16'h0000 : brk_cnt + 16'h0001;
      gp_prev <= gp_now;
      gp_ready <= 1'b1;
      txe_prev <= txe_now;
      st[uev_pkg::ST_TXE] <= (!rd_st && st[uev_pkg::ST_TXE]) || txe_set;
      st[3:0] <= (rd_st ? 4'h0 : st[3:0]) | gp_chg;
      if (!clk_en || sleep_leave) begin
        st[uev_pkg::ST_SLEEP] <= 1'b0;
      end else if (sleep_enter) begin
        st[uev_pkg::ST_SLEEP] <= 1'b1;
      end
      if (!clk_en) begin
        st[uev_pkg::ST_CLK] <= 1'b0;
      end else if (clock_settled && cfg[uev_pkg::CFG_CRYSTAL]) begin
        st[uev_pkg::ST_CLK] <= 1'b1;
      end
    end
  end

  // Sleep, direction and pin outputs.
  always_ff @(posedge aclk) begin
    if (rst) begin
      idle_cnt <= '0;
      sleeping <= 1'b0;
      dstate <= uev_pkg::UEV_D_IDLE;
      rts_pin <= 1'b0;
      rts_oe <= 1'b1;
      tx_pin <= 1'b1;
      tx_oe <= 1'b1;
      tx_permit <= 1'b0;
      tx_halt <= 1'b0;
      rx_enable <= 1'b1;
      isr_special <= 1'b0;
      isr_status <= 1'b0;
      isr_tx_empty <= 1'b0;
    end else begin
      idle_cnt <= (!auto_sleep || line_activity || idle_done) ? '0 : idle_cnt + 1'b1;
      sleeping <= next_sleeping;
      dstate <= next_dstate;
      rts_pin <= auto_dir ? dstate != uev_pkg::UEV_D_IDLE : rts_level;
      rts_oe <= !mode[uev_pkg::MD_RTS_TRI];
      tx_oe <= !mode[uev_pkg::MD_TX_TRI];
      tx_pin <= (mode[uev_pkg::MD_TX_HALT] && tx_shift_idle) || tx_serial;
      tx_permit <= !mode[uev_pkg::MD_TX_HALT] && (!auto_dir || dstate == uev_pkg::UEV_D_SEND);
      tx_halt <= mode[uev_pkg::MD_TX_HALT];
      rx_enable <= !mode[uev_pkg::MD_RX_HALT];
      isr_special <= sc_pend;
      isr_status <= st_pend;
      isr_tx_empty <= auto_dir && tx_fifo_empty;
    end
  end

  a_addr_flag: assert property (@(posedge aclk) disable iff (rst)
    rx_ok && cfg[uev_pkg::CFG_MULTIDROP] && rx_char_is_address |=> sc[uev_pkg::SC_ADDR])
    else $error("address flag not set");
  a_sc_read_clear: assert property (@(posedge aclk) disable iff (rst)
    rd_sc && sc_set == 6'h00 |=> sc == 6'h00)
    else $error("special flags not cleared by read");
  a_break_flag: assert property (@(posedge aclk) disable iff (rst)
    !rx_line && brk_cnt == brk_len && !brk_seen |=> sc[uev_pkg::SC_BREAK])
    else $error("break flag not set");
  a_special_gate: assert property (@(posedge aclk) disable iff (rst)
    $rose(sc[0]) |-> $past(spec_ok))
    else $error("resume flag set without detection enabled");
  // The cycle after a reset compares against pre-reset values, so it is skipped.
  a_summary_one: assert property (@(posedge aclk) disable iff (rst)
    !$past(rst) |-> isr_special == $past(sc_pend))
    else $error("summary bit 1 does not follow enabled flags");
  a_pin_gate: assert property (@(posedge aclk) disable iff (rst)
    $rose(st[0]) |-> $past(st_en[0]))
    else $error("pin flag set while its enable was low");
  a_pin_change: assert property (@(posedge aclk) disable iff (rst)
    gp_ready && st_en[1] && gp_now[1] != gp_prev[1] |=> st[1])
    else $error("pin change not flagged");
  a_sleep_kept: assert property (@(posedge aclk) disable iff (rst)
    rd_st && st[uev_pkg::ST_SLEEP] && clk_en && !sleep_leave |=> st[uev_pkg::ST_SLEEP])
    else $error("sleep flag cleared by read");
  a_force_sleep: assert property (@(posedge aclk) disable iff (rst)
    mode[uev_pkg::MD_SLEEP_FORCE] |=> sleeping)
    else $error("forced sleep not entered");
  a_rts_idle: assert property (@(posedge aclk) disable iff (rst)
    auto_dir && dstate == uev_pkg::UEV_D_IDLE |=> !rts_pin)
    else $error("request-to-send high while idle");
  a_tristate: assert property (@(posedge aclk) disable iff (rst)
    $past(mode[uev_pkg::MD_RTS_TRI]) && !$past(rst) |->
    !rts_oe ##0 (tx_oe == !$past(mode[uev_pkg::MD_TX_TRI])))
    else $error("tristate control not followed");
endmodule

// ===== dv/uev_tx_model.sv
`timescale 1ns/1ns
module uev_tx_model (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [3:0] load, // Characters queued this cycle.
  input wire logic tx_permit, // Shifter may start a character.
  output logic tx_fifo_empty, // Queue empty.
  output logic tx_shift_idle, // Shifter idle.
  output logic tx_serial // Line data.
);
  logic [7:0] cnt;
  logic [3:0] bits;
  wire start = bits == 4'h0 && cnt != 8'h00 && tx_permit;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 8'h00;
      bits <= 4'h0;
    end else begin
      cnt <= cnt + {4'h0, load} - {7'h00, start};
      bits <= start ? 4'ha : bits - {3'h0, bits != 4'h0};
    end
  end
  assign tx_fifo_empty = cnt == 8'h00;
  assign tx_shift_idle = bits == 4'h0;
  // Data bits alternate so that a stale line never looks steady.
  assign tx_serial = tx_shift_idle | bits[0];
endmodule

// ===== dv/uev_top_tb.sv
`timescale 1ns/1ns
module uev_top_tb;
  logic aclk = 0, aresetn = 0, soft_reset = 0, rts_level = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, gpio_in = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0] s_axi_wstrb = 4'hf, rx_char_match = 0, load = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic rx_char_valid = 0, rx_char_is_address = 0, rx_line = 1, clock_settled = 0, line_activity = 0;
  logic tx_fifo_empty, tx_shift_idle, tx_serial, tx_pin, tx_oe, rts_pin, rts_oe, tx_permit, tx_halt;
  logic rx_enable, sleeping, isr_special, isr_status, isr_tx_empty;
  int miscompares = 0, cmp_count = 0, n;
  uev_top #(.CHANNEL(0), .AUTO_SLEEP_CYCLES(50), .DELAY_UNIT(2)) u_dut (.aclk, .aresetn, .soft_reset,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_char_valid,
    .rx_char_is_address, .rx_char_match, .rx_line, .gpio_in, .tx_fifo_empty, .tx_shift_idle, .tx_serial,
    .rts_level, .clock_settled, .line_activity, .tx_pin, .tx_oe, .rts_pin, .rts_oe, .tx_permit, .tx_halt,
    .rx_enable, .sleeping, .isr_special, .isr_status, .isr_tx_empty);
  uev_tx_model u_tx (.aclk, .aresetn, .load, .tx_permit, .tx_fifo_empty, .tx_shift_idle, .tx_serial);
  initial begin
    forever #10 aclk = ~aclk;
  end
  task automatic results();
    $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    $display("ERROR handshake expected answer seen none");
    results();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tk(input int c);
    repeat (c) @(posedge aclk);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [15:0] v, input logic [1:0] er = uev_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 100) hang();
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input logic [31:0] m,
                    input logic [1:0] er = uev_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 100) hang();
    chk("rdata", exp, s_axi_rdata & m);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic chr(input logic adr, input logic [3:0] m);
    @(posedge aclk);
    rx_char_valid <= 1'b1;
    rx_char_is_address <= adr;
    rx_char_match <= m;
    @(posedge aclk);
    rx_char_valid <= 1'b0;
  endtask
  initial begin
    tk(100000);
    hang();
  end
  initial begin
    tk(12);
    aresetn <= 1'b1;
    for (int i = 5; i <= 9; i++) rd(i[5:0], 0, '1);
    wr(uev_pkg::IDX_SC_EN, 16'hff);
    rd(uev_pkg::IDX_SC_EN, 32'h3f, '1);
    wr(uev_pkg::IDX_ST_EN, 16'hff);
    rd(uev_pkg::IDX_ST_EN, 32'hef, '1);
    wr(uev_pkg::IDX_MODE, 16'h80);
    rd(uev_pkg::IDX_MODE, 0, '1);
    wr(6'h00, 16'h55, uev_pkg::RESP_SLVERR);
    rd(6'h3f, 0, '1, uev_pkg::RESP_SLVERR);
    $display("test registers done");
    wr(uev_pkg::IDX_CFG, 16'h0b);
    for (int i = 0; i < 4; i++) begin
      chr(1'b0, 4'h1 << i);
      rd(uev_pkg::IDX_SC_FLAGS, 32'h1 << i, '1);
    end
    wr(uev_pkg::IDX_SC_EN, 16'h00);
    chr(1'b1, 4'h0);
    tk(2);
    chk("isr_special", 0, isr_special);
    wr(uev_pkg::IDX_SC_EN, 16'h20);
    tk(2);
    chk("isr_special", 1, isr_special);
    rd(uev_pkg::IDX_SC_FLAGS, 32'h20, '1);
    rd(uev_pkg::IDX_SC_FLAGS, 0, '1);
    wr(uev_pkg::IDX_CFG, 16'h09);
    chr(1'b0, 4'hf);
    rd(uev_pkg::IDX_SC_FLAGS, 0, '1);
    wr(uev_pkg::IDX_CFG, 16'h0a);
    chr(1'b1, 4'h0);
    rd(uev_pkg::IDX_SC_FLAGS, 0, '1);
    wr(uev_pkg::IDX_MODE, 16'h01);
    tk(2);
    chk("rx_enable", 0, rx_enable);
    wr(uev_pkg::IDX_MODE, 16'h00);
    wr(uev_pkg::IDX_BRK_LEN, 16'h0004);
    rx_line <= 1'b0;
    tk(3);
    rx_line <= 1'b1;
    rd(uev_pkg::IDX_SC_FLAGS, 0, '1);
    rx_line <= 1'b0;
    tk(12);
    rx_line <= 1'b1;
    rd(uev_pkg::IDX_SC_FLAGS, 32'h10, '1);
    $display("test special events done");
    wr(uev_pkg::IDX_ST_EN, 16'h00);
    gpio_in <= 8'h0f;
    rd(uev_pkg::IDX_ST_FLAGS, 0, 32'h0f);
    wr(uev_pkg::IDX_ST_EN, 16'h0f);
    gpio_in <= 8'hff;
    rd(uev_pkg::IDX_ST_FLAGS, 0, 32'h0f);
    gpio_in <= 8'hf6;
    tk(3);
    chk("isr_status", 1, isr_status);
    rd(uev_pkg::IDX_ST_FLAGS, 32'h09, 32'h0f);
    rd(uev_pkg::IDX_ST_FLAGS, 0, 32'h0f);
    clock_settled <= 1'b1;
    rd(uev_pkg::IDX_ST_FLAGS, 0, 32'h20);
    wr(uev_pkg::IDX_CFG, 16'h0c);
    tk(2);
    chk("isr_status", 0, isr_status);
    for (int i = 0; i < 2; i++) rd(uev_pkg::IDX_ST_FLAGS, 32'h20, 32'h20);
    wr(uev_pkg::IDX_CFG, 16'h04);
    rd(uev_pkg::IDX_ST_FLAGS, 0, 32'h20);
    wr(uev_pkg::IDX_CFG, 16'h08);
    wr(uev_pkg::IDX_MODE, 16'h20);
    tk(2);
    chk("sleeping", 1, sleeping);
    rd(uev_pkg::IDX_MODE, 32'h20, '1);
    for (int i = 0; i < 2; i++) rd(uev_pkg::IDX_ST_FLAGS, 32'h40, 32'h40);
    wr(uev_pkg::IDX_MODE, 16'h00);
    tk(2);
    rd(uev_pkg::IDX_ST_FLAGS, 0, 32'h40);
    wr(uev_pkg::IDX_MODE, 16'h40);
    for (n = 0; n < 100 && sleeping !== 1'b1; n++) @(posedge aclk);
    chk("sleep delay", 1, n >= 40 && n < 100);
    rd(uev_pkg::IDX_ST_FLAGS, 32'h40, 32'h40);
    line_activity <= 1'b1;
    tk(3);
    chk("sleeping", 0, sleeping);
    line_activity <= 1'b0;
    wr(uev_pkg::IDX_MODE, 16'h00);
    $display("test status events done");
    rd(uev_pkg::IDX_ST_FLAGS, 0, '1);
    load <= 4'h2;
    tk(1);
    load <= 4'h0;
    tk(2);
    for (n = 0; n < 100 && !(tx_fifo_empty && tx_shift_idle); n++) @(posedge aclk);
    if (n == 100) hang();
    tk(2);
    rd(uev_pkg::IDX_ST_FLAGS, 32'h80, 32'h80);
    rd(uev_pkg::IDX_ST_FLAGS, 0, 32'h80);
    wr(uev_pkg::IDX_MODE, 16'h02);
    load <= 4'h1;
    tk(1);
    load <= 4'h0;
    tk(30);
    chk("tx_halt", 1, tx_halt);
    chk("tx_pin", 1, tx_pin);
    chk("fifo kept", 0, tx_fifo_empty);
    wr(uev_pkg::IDX_MODE, 16'h0c);
    tk(2);
    chk("tx_oe", 0, tx_oe);
    chk("rts_oe", 0, rts_oe);
    wr(uev_pkg::IDX_MODE, 16'h10);
    wr(uev_pkg::IDX_DIR_DELAY, 16'h21);
    tk(40);
    chk("rts_pin idle", 0, rts_pin);
    load <= 4'h1;
    tk(1);
    load <= 4'h0;
    for (n = 0; n < 50 && rts_pin !== 1'b1; n++) @(posedge aclk);
    if (n == 50) hang();
    for (n = 0; n < 50 && tx_permit !== 1'b1; n++) @(posedge aclk);
    if (n == 50) hang();
    chk("setup", 1, n >= 3 && n < 50 && rts_pin === 1'b1);
    for (n = 0; n < 100 && !(tx_fifo_empty && tx_shift_idle); n++) @(posedge aclk);
    if (n == 100) hang();
    tk(2);
    chk("isr_tx_empty", 1, isr_tx_empty);
    for (n = 0; n < 50 && rts_pin !== 1'b0; n++) @(posedge aclk);
    chk("rts_pin after", 0, rts_pin);
    wr(uev_pkg::IDX_DIR_DELAY, 16'h00);
    load <= 4'h1;
    tk(1);
    load <= 4'h0;
    tk(3);
    chk("rts_pin zero setup", 1, rts_pin);
    $display("test line mode done");
    soft_reset <= 1'b1;
    tk(1);
    soft_reset <= 1'b0;
    rd(uev_pkg::IDX_SC_EN, 0, '1);
    rd(uev_pkg::IDX_BRK_LEN, {16'h0000, uev_pkg::BRK_LEN_RESET}, '1);
    $display("test soft reset done");
    results();
  end
endmodule
